// ==== common/sfrm_regs.svh ====
// Purpose: register map, field positions and timing for the fault manager
// Assumes: 16-bit register words, 8-bit register addresses
// Notes: all delay registers count in ticks of the common time base
`ifndef SFRM_REGS_SVH
`define SFRM_REGS_SVH

// ==========================================
// Timing
`define SFRM_CLK_NS 10
`define SFRM_TICK_NS 1000
`define SFRM_TICK_CYC (`SFRM_TICK_NS / `SFRM_CLK_NS)
`define SFRM_DEGLITCH_US 10
`define SFRM_RESET_MIN_US 100
`define SFRM_US_TICKS(us) (((us) * 1000 + `SFRM_TICK_NS - 1) / `SFRM_TICK_NS)

// ==========================================
// Register addresses
`define SFRM_A_GLOBAL 8'h00
`define SFRM_A_OPER 8'h01
`define SFRM_A_CLEAR 8'h02
`define SFRM_A_HOLD 8'h03
`define SFRM_A_RETRY 8'h04
`define SFRM_A_PERSIST 8'h05
`define SFRM_A_GOODMAP 8'h06
`define SFRM_A_CUTOV 8'h07
`define SFRM_A_CUTUV 8'h08
`define SFRM_A_STOV 8'h09
`define SFRM_A_STUV 8'h0a
`define SFRM_A_STWARN 8'h0b
`define SFRM_A_STATE 8'h0c
`define SFRM_A_SETUP 8'h10
`define SFRM_A_MAP 8'h18
`define SFRM_A_TON 8'h20

// ==========================================
// Fields
`define SFRM_F_SHARE 0
`define SFRM_F_POL 0
`define SFRM_F_FS 1
`define SFRM_F_RUN 2
`define SFRM_F_OVA 3
`define SFRM_F_UVA 5
`define SFRM_F_RETRY 7
`define SFRM_F_EXP 0
`define SFRM_F_IMP 4

// ==========================================
// Fault actions
`define SFRM_ACT_IGNORE 2'h0
`define SFRM_ACT_IMM 2'h1
`define SFRM_ACT_PERSIST 2'h2

// ==========================================
// Reset values
`define SFRM_RST_WORD 16'h0000
`define SFRM_RST_HOLD 16'h03e8
`define SFRM_RST_RETRY 16'h2710
`define SFRM_RST_PERSIST 16'h0064
`define SFRM_RST_BYTE 8'h00
`endif

// ==== common/sfrm_pkg.sv ====
// Purpose: shared types of the fault manager
// Assumes: nothing
// Notes: state codes are left to synthesis
package sfrm_pkg;
	typedef logic [15:0] sfrm_word_t;
	typedef enum logic [2:0]
	{
		CH_OFF,
		CH_HOLD,
		CH_TON,
		CH_ON,
		CH_FLT,
		CH_ZONE
	} sfrm_chan_state_t;
endpackage

// ==== common/sfrm_tick_if.sv ====
// Purpose: carries the common time base tick between modules
// Assumes: one clock
// Notes: tick is one mclk cycle wide
`timescale 1ns/1ns
interface sfrm_tick_if;
	logic tick;
	modport src (output tick);
	modport snk (input tick);
endinterface

// ==== hw/sfrm_timebase.sv ====
// Purpose: divides mclk to the common time base tick
// Assumes: DIV of at least 2
// Notes: every delay of the block counts these ticks
`timescale 1ns/1ns
module sfrm_timebase
	import sfrm_pkg::*;
#(
	parameter int DIV = 100
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Tick out
	sfrm_tick_if.src tb
);
	localparam int CW = $clog2(DIV);
	logic [CW-1:0] div_reg;
	logic tick_reg;

	assign tb.tick = tick_reg;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			tick_reg <= (div_reg == CW'(DIV - 1));
			if (div_reg == CW'(DIV - 1))
				div_reg <= '0;
			else
				div_reg <= div_reg + 1'b1;
		end
	end
endmodule

// ==== hw/sfrm_deglitch.sv ====
// Purpose: synchronises pins and passes a level only once it is stable
// Assumes: tick from the common time base
// Notes: stable time is STABLE ticks, less up to one tick of phase
`timescale 1ns/1ns
module sfrm_deglitch
	import sfrm_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter int STABLE = 10,
	parameter logic [WIDTH-1:0] INIT = '0
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Time base
	sfrm_tick_if.snk tb,
	// Levels
	input wire logic [WIDTH-1:0] rawIn,
	output logic [WIDTH-1:0] filtOut
);
	localparam int CW = $clog2(STABLE + 1);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= INIT;
			sync_reg <= INIT;
		end
		else
		begin
			meta_reg <= rawIn;
			sync_reg <= meta_reg;
		end
	end

	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		logic [CW-1:0] cnt_reg;
		logic flt_reg;
		assign filtOut[i] = flt_reg;
		always_ff @(posedge mclk or posedge rst)
		begin
			if (rst)
			begin
				cnt_reg <= '0;
				flt_reg <= INIT[i];
			end
			else if (sync_reg[i] == flt_reg)
				cnt_reg <= '0;
			else if (tb.tick)
			begin
				if (cnt_reg == CW'(STABLE - 1))
				begin
					flt_reg <= sync_reg[i];
					cnt_reg <= '0;
				end
				else
					cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end
endmodule

// ==== hw/supply_fault_restart_manager.sv ====
// Purpose: fault response, restart and zone propagation for 8 channels
// Assumes: trip and ADC inputs come from logic on mclk
// Notes: zone, run, reset and share pins are synchronised inside
`timescale 1ns/1ns
`include "sfrm_regs.svh"

module supply_fault_restart_manager
	import sfrm_pkg::*;
#(
	parameter int NCH = 8,
	parameter int ZCH = 4,
	parameter int RESET_TICKS = `SFRM_US_TICKS(`SFRM_RESET_MIN_US)
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdata,
	// Supervisor and ADC results
	input wire logic [NCH-1:0] ovTrip,
	input wire logic [NCH-1:0] uvTrip,
	input wire logic [NCH-1:0] ovWarn,
	input wire logic [NCH-1:0] uvWarn,
	input wire logic [NCH-1:0] adcGood,
	input wire logic inputSenseOk,
	// Pins
	input wire logic [1:0] runPin,
	input wire logic watchdogResetPinN,
	input wire logic [3:0] zoneFaultLineIn,
	output logic [3:0] zoneFaultLineOut,
	output logic [3:0] zoneFaultLineOe,
	input wire logic shareLineIn,
	output logic shareLineOut,
	output logic shareLineOe,
	// Outputs
	output logic [NCH-1:0] converterEnableOut,
	output logic alertLineLow,
	output logic busCutLow,
	output logic powerGoodOut,
	output logic [NCH-1:0] dacPolarity,
	output logic [NCH-1:0] dacFullScaleHigh
);
	// ==========================================
	// Time base and pin filters
	sfrm_tick_if tbIf ();
	logic [5:0] filtLines;
	logic wdFilt;
	logic [1:0] runOn;
	logic [3:0] lineLow;
	logic porHold;

	sfrm_timebase #(.DIV(`SFRM_TICK_CYC)) uTimebase
	(
		.mclk(mclk),
		.rst(rst),
		.tb(tbIf.src)
	);

	sfrm_deglitch #(
		.WIDTH(6),
		.STABLE(`SFRM_US_TICKS(`SFRM_DEGLITCH_US)),
		.INIT(6'h3c)
	) uLineFilt
	(
		.mclk(mclk),
		.rst(rst),
		.tb(tbIf.snk),
		.rawIn({zoneFaultLineIn, runPin}),
		.filtOut(filtLines)
	);

	sfrm_deglitch #(.WIDTH(1), .STABLE(RESET_TICKS), .INIT(1'b1)) uWdFilt
	(
		.mclk(mclk),
		.rst(rst),
		.tb(tbIf.snk),
		.rawIn(watchdogResetPinN),
		.filtOut(wdFilt)
	);

	assign runOn = filtLines[1:0];
	assign lineLow = ~filtLines[5:2];
	assign porHold = ~wdFilt;

	// ==========================================
	// Registers
	logic shareSync_reg;
	logic [7:0] oper_reg;
	sfrm_word_t hold_reg;
	sfrm_word_t retry_reg;
	sfrm_word_t persist_reg;
	logic [7:0] goodMap_reg;
	logic [7:0] cutOv_reg;
	logic [7:0] cutUv_reg;
	sfrm_word_t setup_reg [NCH];
	logic [7:0] map_reg [NCH];
	sfrm_word_t ton_reg [NCH];
	logic operWr;
	logic clearWr;

	assign operWr = regWrite && regAddr == `SFRM_A_OPER;
	assign clearWr = regWrite && regAddr == `SFRM_A_CLEAR;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			shareSync_reg <= 1'b0;
			oper_reg <= `SFRM_RST_BYTE;
			hold_reg <= `SFRM_RST_HOLD;
			retry_reg <= `SFRM_RST_RETRY;
			persist_reg <= `SFRM_RST_PERSIST;
			goodMap_reg <= `SFRM_RST_BYTE;
			cutOv_reg <= `SFRM_RST_BYTE;
			cutUv_reg <= `SFRM_RST_BYTE;
			for (int i = 0; i < NCH; i++)
			begin
				setup_reg[i] <= `SFRM_RST_WORD;
				map_reg[i] <= `SFRM_RST_BYTE;
				ton_reg[i] <= `SFRM_RST_WORD;
			end
		end
		else if (porHold)
		begin
			shareSync_reg <= 1'b0;
			oper_reg <= `SFRM_RST_BYTE;
			hold_reg <= `SFRM_RST_HOLD;
			retry_reg <= `SFRM_RST_RETRY;
			persist_reg <= `SFRM_RST_PERSIST;
			goodMap_reg <= `SFRM_RST_BYTE;
			cutOv_reg <= `SFRM_RST_BYTE;
			cutUv_reg <= `SFRM_RST_BYTE;
			for (int i = 0; i < NCH; i++)
			begin
				setup_reg[i] <= `SFRM_RST_WORD;
				map_reg[i] <= `SFRM_RST_BYTE;
				ton_reg[i] <= `SFRM_RST_WORD;
			end
		end
		else if (regWrite)
		begin
			case (regAddr)
				`SFRM_A_GLOBAL: shareSync_reg <= regWdata[`SFRM_F_SHARE];
				`SFRM_A_OPER: oper_reg <= regWdata[7:0];
				`SFRM_A_HOLD: hold_reg <= regWdata;
				`SFRM_A_RETRY: retry_reg <= regWdata;
				`SFRM_A_PERSIST: persist_reg <= regWdata;
				`SFRM_A_GOODMAP: goodMap_reg <= regWdata[7:0];
				`SFRM_A_CUTOV: cutOv_reg <= regWdata[7:0];
				`SFRM_A_CUTUV: cutUv_reg <= regWdata[7:0];
				default:
				begin
					for (int i = 0; i < NCH; i++)
					begin
						if (regAddr == `SFRM_A_SETUP + 8'(i))
							setup_reg[i] <= regWdata;
						if (regAddr == `SFRM_A_MAP + 8'(i))
							map_reg[i] <= regWdata[7:0];
						if (regAddr == `SFRM_A_TON + 8'(i))
							ton_reg[i] <= regWdata;
					end
				end
			endcase
		end
	end

	// ==========================================
	// Input bias and shared sequencing line
	logic shareMeta_reg;
	logic shareSyncIn_reg;
	logic vinOk;
	logic vinPrev_reg;
	logic vinRestore;
	logic [1:0] runPrev_reg;
	logic [1:0] restartEv;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			shareMeta_reg <= 1'b1;
			shareSyncIn_reg <= 1'b1;
			vinPrev_reg <= 1'b0;
			runPrev_reg <= 2'h0;
		end
		else
		begin
			shareMeta_reg <= shareLineIn;
			shareSyncIn_reg <= shareMeta_reg;
			vinPrev_reg <= vinOk;
			runPrev_reg <= runOn;
		end
	end

	// Holding the line low until local bias is good lets all devices
	// start together on the last one to see its input come up.
	assign shareLineOut = 1'b0;
	assign shareLineOe = shareSync_reg && !inputSenseOk;
	assign vinOk = inputSenseOk && (!shareSync_reg || shareSyncIn_reg);
	assign vinRestore = vinOk && !vinPrev_reg;
	// Filter already demanded the low level for the deglitch time
	assign restartEv = runOn & ~runPrev_reg;

	// ==========================================
	// Channel sequencers
	logic [NCH-1:0] faultOff;
	logic [NCH-1:0] cutOvSet;
	logic [NCH-1:0] cutUvSet;
	logic [NCH-1:0] reOn;
	sfrm_chan_state_t chState [NCH];

	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		sfrm_chan_state_t state_reg;
		sfrm_word_t cnt_reg;
		sfrm_word_t pers_reg;
		logic runSel;
		logic wantOn;
		logic [1:0] zLow;
		logic zoneTrip;
		logic immTrip;
		logic perTrip;
		logic goFault;
		logic clearLatch;
		logic [1:0] ovAct;
		logic [1:0] uvAct;

		assign runSel = setup_reg[c][`SFRM_F_RUN];
		assign wantOn = oper_reg[c] && runOn[runSel] && vinOk;
		assign zLow = lineLow[2*(c/ZCH) +: 2];
		assign zoneTrip = |(map_reg[c][`SFRM_F_IMP +: 2] & zLow);
		assign ovAct = setup_reg[c][`SFRM_F_OVA +: 2];
		assign uvAct = setup_reg[c][`SFRM_F_UVA +: 2];
		assign immTrip = (ovTrip[c] && ovAct == `SFRM_ACT_IMM)
			|| (uvTrip[c] && uvAct == `SFRM_ACT_IMM);
		assign perTrip = (ovTrip[c] && ovAct == `SFRM_ACT_PERSIST)
			|| (uvTrip[c] && uvAct == `SFRM_ACT_PERSIST);
		assign goFault = state_reg == CH_ON
			&& (immTrip || (perTrip && pers_reg >= persist_reg));
		assign clearLatch = restartEv[runSel] || vinRestore
			|| (operWr && regWdata[c]);
		assign faultOff[c] = state_reg == CH_FLT;
		assign cutOvSet[c] = goFault && ovTrip[c] && cutOv_reg[c];
		assign cutUvSet[c] = goFault && uvTrip[c] && cutUv_reg[c];
		assign reOn[c] = operWr && regWdata[c] && state_reg == CH_FLT;
		assign chState[c] = state_reg;

		// Persistence only grows while the trip holds
		always_ff @(posedge mclk or posedge rst)
		begin
			if (rst)
				pers_reg <= '0;
			else if (porHold || !perTrip || state_reg != CH_ON)
				pers_reg <= '0;
			else if (tbIf.tick && pers_reg != 16'hffff)
				pers_reg <= pers_reg + 1'b1;
		end

		always_ff @(posedge mclk or posedge rst)
		begin
			if (rst)
			begin
				state_reg <= CH_OFF;
				cnt_reg <= '0;
			end
			else if (porHold)
			begin
				state_reg <= CH_OFF;
				cnt_reg <= '0;
			end
			else
			begin
				case (state_reg)
					CH_OFF:
					begin
						if (restartEv[runSel])
						begin
							state_reg <= CH_HOLD;
							cnt_reg <= hold_reg;
						end
						else if (wantOn)
						begin
							state_reg <= CH_TON;
							cnt_reg <= ton_reg[c];
						end
					end
					CH_HOLD:
					begin
						if (cnt_reg == '0)
						begin
							state_reg <= CH_TON;
							cnt_reg <= ton_reg[c];
						end
						else if (tbIf.tick)
							cnt_reg <= cnt_reg - 1'b1;
					end
					CH_TON:
					begin
						if (!wantOn)
							state_reg <= CH_OFF;
						else if (zoneTrip)
							state_reg <= CH_ZONE;
						else if (cnt_reg == '0)
							state_reg <= CH_ON;
						else if (tbIf.tick)
							cnt_reg <= cnt_reg - 1'b1;
					end
					CH_ON:
					begin
						if (goFault)
						begin
							state_reg <= CH_FLT;
							cnt_reg <= retry_reg;
						end
						else if (zoneTrip)
							state_reg <= CH_ZONE;
						else if (restartEv[runSel])
						begin
							state_reg <= CH_HOLD;
							cnt_reg <= hold_reg;
						end
						else if (!wantOn)
							state_reg <= CH_OFF;
					end
					CH_FLT:
					begin
						if (clearLatch)
							state_reg <= CH_OFF;
						else if (setup_reg[c][`SFRM_F_RETRY])
						begin
							if (cnt_reg == '0)
							begin
								state_reg <= CH_TON;
								cnt_reg <= ton_reg[c];
							end
							else if (tbIf.tick)
								cnt_reg <= cnt_reg - 1'b1;
						end
					end
					CH_ZONE:
					begin
						if (!wantOn)
							state_reg <= CH_OFF;
						else if (!zoneTrip)
						begin
							state_reg <= CH_TON;
							cnt_reg <= ton_reg[c];
						end
					end
					default: state_reg <= CH_OFF;
				endcase
			end
		end

		// Warnings are absent here so they can never switch off
		always_ff @(posedge mclk or posedge rst)
		begin
			if (rst)
				converterEnableOut[c] <= 1'b0;
			else
				converterEnableOut[c] <= !porHold
					&& state_reg == CH_ON;
		end

		assign dacPolarity[c] = setup_reg[c][`SFRM_F_POL];
		assign dacFullScaleHigh[c] = setup_reg[c][`SFRM_F_FS];
	end

	// ==========================================
	// Zone line export
	always_comb
	begin
		zoneFaultLineOut = 4'h0;
		zoneFaultLineOe = 4'h0;
		for (int l = 0; l < 4; l++)
			for (int c = 0; c < NCH; c++)
				if (c / ZCH == l / 2 && faultOff[c]
					&& map_reg[c][`SFRM_F_EXP + l % 2])
					zoneFaultLineOe[l] = 1'b1;
	end

	// ==========================================
	// Status, alert and bus cut
	logic [7:0] stOv_reg;
	logic [7:0] stUv_reg;
	logic [15:0] stWarn_reg;
	logic cut_reg;

	// Set beats clear so a trip in the clear cycle is kept
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			stOv_reg <= 8'h00;
			stUv_reg <= 8'h00;
			stWarn_reg <= 16'h0000;
		end
		else if (porHold)
		begin
			stOv_reg <= 8'h00;
			stUv_reg <= 8'h00;
			stWarn_reg <= 16'h0000;
		end
		else
		begin
			stOv_reg <= (clearWr ? 8'h00 : stOv_reg) | ovTrip;
			stUv_reg <= (clearWr ? 8'h00 : stUv_reg) | uvTrip;
			stWarn_reg <= (clearWr ? 16'h0000 : stWarn_reg)
				| {ovWarn, uvWarn};
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			cut_reg <= 1'b0;
		else if (porHold)
			cut_reg <= 1'b0;
		else if (|(cutOvSet | cutUvSet))
			cut_reg <= 1'b1;
		else if (|reOn)
			cut_reg <= 1'b0;
	end

	assign alertLineLow = |{stOv_reg, stUv_reg, stWarn_reg};
	assign busCutLow = cut_reg;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			powerGoodOut <= 1'b0;
		else
			powerGoodOut <= &(adcGood | ~goodMap_reg);
	end

	// ==========================================
	// Read port
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			regRdata <= 16'h0000;
		else if (!regRead)
			regRdata <= 16'h0000;
		else
		begin
			regRdata <= 16'h0000;
			case (regAddr)
				`SFRM_A_GLOBAL: regRdata <= {15'h0000, shareSync_reg};
				`SFRM_A_OPER: regRdata <= {8'h00, oper_reg};
				`SFRM_A_HOLD: regRdata <= hold_reg;
				`SFRM_A_RETRY: regRdata <= retry_reg;
				`SFRM_A_PERSIST: regRdata <= persist_reg;
				`SFRM_A_GOODMAP: regRdata <= {8'h00, goodMap_reg};
				`SFRM_A_CUTOV: regRdata <= {8'h00, cutOv_reg};
				`SFRM_A_CUTUV: regRdata <= {8'h00, cutUv_reg};
				`SFRM_A_STOV: regRdata <= {8'h00, stOv_reg};
				`SFRM_A_STUV: regRdata <= {8'h00, stUv_reg};
				`SFRM_A_STWARN: regRdata <= stWarn_reg;
				`SFRM_A_STATE: regRdata <= {faultOff, converterEnableOut};
				default:
				begin
					for (int i = 0; i < NCH; i++)
					begin
						if (regAddr == `SFRM_A_SETUP + 8'(i))
							regRdata <= setup_reg[i];
						if (regAddr == `SFRM_A_MAP + 8'(i))
							regRdata <= {8'h00, map_reg[i]};
						if (regAddr == `SFRM_A_TON + 8'(i))
							regRdata <= ton_reg[i];
					end
				end
			endcase
		end
	end
endmodule

// ==== sim/sfrm_far_model.sv ====
// Purpose: converters and peer managers beside the fault manager
// Assumes: lines carry pull-ups on the board
// Notes: peers pull zone lines low on the bench's request
`timescale 1ns/1ns
module sfrm_far_model
#(
	parameter int NCH = 8
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Device pins
	input wire logic [NCH-1:0] converterEnableOut,
	input wire logic [3:0] zoneFaultLineOe,
	input wire logic shareLineOe,
	// Peer requests
	input wire logic [3:0] peerPull,
	// Levels back to the device
	output logic [3:0] zoneFaultLineIn,
	output logic shareLineIn,
	output logic [NCH-1:0] adcGood
);
	logic [NCH-1:0] rampA;
	// Wired low wins over the pull-up
	assign zoneFaultLineIn = ~(zoneFaultLineOe | peerPull);
	assign shareLineIn = ~shareLineOe;
	// Output good lags enable by two cycles, falls one cycle after it
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rampA <= '0;
			adcGood <= '0;
		end
		else
		begin
			rampA <= converterEnableOut;
			adcGood <= rampA & converterEnableOut;
		end
	end
endmodule

// ==== sim/sfrm_assertions.sv ====
// Purpose: port-level checks of the fault manager
// Assumes: tick of 100 mclk cycles
// Notes: bound into the top module
`timescale 1ns/1ns
`include "sfrm_regs.svh"
module sfrm_checker
#(
	parameter int NCH = 8,
	parameter int RESET_TICKS = 3
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regRdata,
	// Events
	input wire logic [NCH-1:0] ovTrip,
	input wire logic [NCH-1:0] uvTrip,
	input wire logic [NCH-1:0] ovWarn,
	input wire logic [NCH-1:0] uvWarn,
	input wire logic watchdogResetPinN,
	// Outputs
	input wire logic [3:0] zoneFaultLineOut,
	input wire logic [3:0] zoneFaultLineOe,
	input wire logic [NCH-1:0] converterEnableOut,
	input wire logic alertLineLow,
	input wire logic busCutLow,
	input wire logic [NCH-1:0] dacPolarity,
	input wire logic [NCH-1:0] dacFullScaleHigh
);
	// Filter takes at most its nominal time; two ticks of margin
	localparam int WD_CYC = (RESET_TICKS + 2) * 100;
	logic [1:0] ovAct0;
	int lowCnt;
	wire operW = regWrite && regAddr == `SFRM_A_OPER;
	wire tripAny = |(ovTrip | uvTrip);
	wire anyIn = tripAny || |(ovWarn | uvWarn);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			ovAct0 <= 2'h0;
		else if (regWrite && regAddr == `SFRM_A_SETUP)
			ovAct0 <= regWdata[4:3];
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			lowCnt <= 0;
		else if (watchdogResetPinN)
			lowCnt <= 0;
		else if (lowCnt < WD_CYC)
			lowCnt <= lowCnt + 1;
	property p_rd_idle; !$past(regRead) |-> regRdata == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside its cycle");
	property p_warn; (|(ovWarn | uvWarn)) |=> alertLineLow; endproperty
	a_warn: assert property (p_warn)
		else $error("warning without alert");
	property p_clear;
		(regWrite && regAddr == `SFRM_A_CLEAR && !anyIn) ##1 !anyIn
			|=> !alertLineLow;
	endproperty
	a_clear: assert property (p_clear)
		else $error("alert kept after clear");
	// A line is only claimed by a faulted-off channel, on entering that state or on a write of its export bit
	property p_zone_out;
		$rose(|zoneFaultLineOe) |-> zoneFaultLineOut == 4'h0
			&& ($past(tripAny) || $past(regWrite));
	endproperty
	a_zone_out: assert property (p_zone_out)
		else $error("zone line driven high");
	property p_wd;
		lowCnt == WD_CYC |-> converterEnableOut == '0 && !busCutLow
			&& !alertLineLow;
	endproperty
	a_wd: assert property (p_wd)
		else $error("reset pin did not reset");
	property p_imm;
		converterEnableOut[0] && ovTrip[0] && ovAct0 == 2'h1
			|-> ##[1:3] !converterEnableOut[0];
	endproperty
	a_imm: assert property (p_imm)
		else $error("immediate trip kept enable");
	property p_cut;
		$rose(busCutLow) |-> $past(tripAny) || $past(tripAny, 2)
			|| $past(tripAny, 3);
	endproperty
	a_cut: assert property (p_cut)
		else $error("bus cut without trip");
	property p_cut_rel;
		$fell(busCutLow) |-> $past(operW) || $past(operW, 2)
			|| $past(operW, 3) || lowCnt != 0;
	endproperty
	a_cut_rel: assert property (p_cut_rel)
		else $error("bus cut released without on command");
	property p_dac;
		regWrite && regAddr[7:3] == 5'h02 |=>
			dacPolarity[$past(regAddr[2:0])] == $past(regWdata[0]) &&
			dacFullScaleHigh[$past(regAddr[2:0])] == $past(regWdata[1]);
	endproperty
	a_dac: assert property (p_dac)
		else $error("trim setup not shown");
	c_trip: cover property (converterEnableOut[0] && ovTrip[0]);
	c_cut: cover property ($rose(busCutLow));
	c_wd: cover property (lowCnt == WD_CYC);
endmodule
bind supply_fault_restart_manager sfrm_checker #(.NCH(NCH),
	.RESET_TICKS(RESET_TICKS)) u_sfrm_checker (.mclk, .rst, .regAddr,
	.regWdata, .regWrite, .regRead, .regRdata, .ovTrip, .uvTrip, .ovWarn,
	.uvWarn, .watchdogResetPinN, .zoneFaultLineOut, .zoneFaultLineOe,
	.converterEnableOut,
	.alertLineLow, .busCutLow, .dacPolarity, .dacFullScaleHigh);

// ==== sim/supply_fault_restart_manager_bench.sv ====
// Purpose: directed tests of the fault manager
// Assumes: tick of 100 mclk cycles
// Notes: short delay registers keep the run brief
`timescale 1ns/1ns
`include "sfrm_regs.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
	err_total++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module supply_fault_restart_manager_bench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [15:0] regWdata = 16'h0000;
	logic regWrite = 1'b0, regRead = 1'b0, inputSenseOk = 1'b0;
	logic [7:0] ovTrip = 8'h00, uvTrip = 8'h00;
	logic [7:0] ovWarn = 8'h00, uvWarn = 8'h00;
	logic [1:0] runPin = 2'h0;
	logic watchdogResetPinN = 1'b1;
	logic [3:0] peerPull = 4'h0;
	logic [15:0] regRdata;
	logic [7:0] adcGood, en, dacPolarity, dacFullScaleHigh;
	logic [3:0] zIn, zOe;
	logic shIn, shOe, alertLineLow, busCutLow, powerGoodOut;
	int err_total = 0;
	int cmp_count = 0;
	supply_fault_restart_manager #(.RESET_TICKS(3))
	u_supply_fault_restart_manager (.mclk, .rst, .regAddr, .regWdata,
		.regWrite, .regRead, .regRdata, .ovTrip, .uvTrip, .ovWarn, .uvWarn,
		.adcGood, .inputSenseOk, .runPin, .watchdogResetPinN,
		.zoneFaultLineIn(zIn), .zoneFaultLineOut(), .zoneFaultLineOe(zOe),
		.shareLineIn(shIn), .shareLineOut(), .shareLineOe(shOe),
		.converterEnableOut(en), .alertLineLow, .busCutLow, .powerGoodOut,
		.dacPolarity, .dacFullScaleHigh);
	sfrm_far_model u_sfrm_far_model (.mclk, .rst, .converterEnableOut(en),
		.zoneFaultLineOe(zOe), .shareLineOe(shOe), .peerPull,
		.zoneFaultLineIn(zIn), .shareLineIn(shIn), .adcGood);
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		@(negedge mclk);
		`CHK($sformatf("reg%h", a), e, regRdata)
	endtask
	// Bounded wait in ticks for one enable
	task automatic waitEn(input int i, input logic v, input int lim);
		int k;
		k = 0;
		@(negedge mclk);
		while (en[i] !== v && k < lim * 100)
		begin
			@(negedge mclk);
			k++;
		end
		`CHK($sformatf("en%0d", i), v, en[i])
	endtask
	task automatic stop_test;
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		#500000;
		err_total++;
		stop_test();
	end
	initial
	begin
		wt(2);
		rst <= 1'b0;
		rd(`SFRM_A_HOLD, `SFRM_RST_HOLD);
		rd(`SFRM_A_RETRY, `SFRM_RST_RETRY);
		rd(`SFRM_A_PERSIST, `SFRM_RST_PERSIST);
		rd(8'h3f, 16'h0000);
		wr(`SFRM_A_HOLD, 16'h0004);
		wr(`SFRM_A_RETRY, 16'h0014);
		wr(`SFRM_A_PERSIST, 16'h0004);
		wr(`SFRM_A_GOODMAP, 16'h0001);
		wr(`SFRM_A_CUTOV, 16'h0001);
		wr(`SFRM_A_TON, 16'h0005);
		wr(8'h10, 16'h000b);
		wr(8'h12, 16'h00c0);
		wr(8'h15, 16'h0004);
		wr(8'h18, 16'h0001);
		wr(8'h1b, 16'h0010);
		wr(8'h1c, 16'h0010);
		wr(`SFRM_A_OPER, 16'h00ff);
		@(negedge mclk);
		`CHK("dacPolarity", 8'h01, dacPolarity)
		`CHK("dacFullScaleHigh", 8'h01, dacFullScaleHigh)
		// First start counts as a restart
		wt(1);
		inputSenseOk <= 1'b1;
		runPin <= 2'h1;
		wt(1000);
		@(negedge mclk);
		`CHK("en", 8'h00, en)
		waitEn(1, 1'b1, 10);
		`CHK("en0", 1'b0, en[0])
		waitEn(0, 1'b1, 7);
		`CHK("en", 8'hdf, en)
		wt(3);
		@(negedge mclk);
		`CHK("powerGood", 1'b1, powerGoodOut)
		wt(1);
		ovWarn <= 8'h02;
		uvWarn <= 8'h40;
		wt(1);
		ovWarn <= 8'h00;
		uvWarn <= 8'h00;
		wt(3);
		@(negedge mclk);
		`CHK("alert", 1'b1, alertLineLow)
		`CHK("en", 8'hdf, en)
		rd(`SFRM_A_STWARN, 16'h0240);
		wr(`SFRM_A_CLEAR, 16'h0000);
		rd(`SFRM_A_STWARN, 16'h0000);
		`CHK("alert", 1'b0, alertLineLow)
		// Ch0 trips and shuts ch3 through zone line 0
		wt(1);
		ovTrip <= 8'h03;
		wt(1);
		ovTrip <= 8'h00;
		wt(3);
		@(negedge mclk);
		`CHK("en", 8'hde, en)
		`CHK("busCut", 1'b1, busCutLow)
		`CHK("zoneOe", 4'h1, zOe)
		rd(`SFRM_A_STOV, 16'h0003);
		waitEn(3, 1'b0, 13);
		`CHK("en2", 1'b1, en[2])
		wt(2500);
		@(negedge mclk);
		`CHK("en0", 1'b0, en[0])
		wr(`SFRM_A_OPER, 16'h00ff);
		wt(2);
		@(negedge mclk);
		`CHK("busCut", 1'b0, busCutLow)
		waitEn(0, 1'b1, 8);
		waitEn(3, 1'b1, 15);
		// Short UV rides through, long UV off then retry
		wt(1);
		uvTrip <= 8'h04;
		wt(200);
		uvTrip <= 8'h00;
		wt(500);
		@(negedge mclk);
		`CHK("en2", 1'b1, en[2])
		wt(1);
		uvTrip <= 8'h04;
		waitEn(2, 1'b0, 7);
		wt(1);
		uvTrip <= 8'h00;
		@(negedge mclk);
		`CHK("busCut", 1'b0, busCutLow)
		wt(1500);
		@(negedge mclk);
		`CHK("en2", 1'b0, en[2])
		waitEn(2, 1'b1, 10);
		// Peer pulls zone 1 line 0
		wt(1);
		peerPull <= 4'h4;
		wt(800);
		@(negedge mclk);
		`CHK("en4", 1'b1, en[4])
		waitEn(4, 1'b0, 4);
		wt(1);
		peerPull <= 4'h0;
		waitEn(4, 1'b1, 13);
		wt(1);
		runPin <= 2'h3;
		waitEn(5, 1'b1, 16);
		// Run pin 0 pulsed off: only its channels restart
		wt(1);
		runPin <= 2'h2;
		wt(2000);
		runPin <= 2'h3;
		wt(1100);
		@(negedge mclk);
		`CHK("en", 8'h20, en)
		waitEn(1, 1'b1, 10);
		// Share sync: line held low while local bias is missing
		wr(`SFRM_A_GLOBAL, 16'h0001);
		inputSenseOk <= 1'b0;
		@(negedge mclk);
		`CHK("shareOe", 1'b1, shOe)
		wt(1);
		inputSenseOk <= 1'b1;
		@(negedge mclk);
		`CHK("shareOe", 1'b0, shOe)
		wt(1);
		watchdogResetPinN <= 1'b0;
		wt(600);
		@(negedge mclk);
		`CHK("en", 8'h00, en)
		wt(1);
		watchdogResetPinN <= 1'b1;
		wt(600);
		rd(`SFRM_A_HOLD, `SFRM_RST_HOLD);
		stop_test();
	end
endmodule
